// *** pkg/tdc_qual_pkg.sv ***
package tdc_qual_pkg;
  // Clock rate and timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CONV_32CH_NS = 5700;
  localparam int unsigned CONV_16CH_NS = 2800;
  localparam int unsigned CONV_32CH_CYC = CONV_32CH_NS * CLK_MHZ / 1000;
  localparam int unsigned CONV_16CH_CYC = CONV_16CH_NS * CLK_MHZ / 1000;
  localparam int unsigned SELF_RESET_NS = 700;
  localparam int unsigned SELF_RESET_CYC = (SELF_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLEAR_CYC = 8;
  // Channels and widths
  localparam int unsigned NUM_CH = 32;
  localparam int unsigned GROUP_SIZE = 4;
  localparam int unsigned HALF_CH = 16;
  localparam int unsigned ADC_W = 12;
  // Threshold memory
  localparam logic [15:0] THR_MEM_BASE = 16'h1080;
  localparam logic [15:0] THR_MEM_LAST = 16'h10bf;
  localparam int unsigned THR_KILL_BIT = 8;
  // Second bit-set configuration register fields
  localparam int unsigned CFG_KEEP_BELOW_BIT = 4;
  localparam int unsigned CFG_STEP_BIT = 8;
  localparam int unsigned CFG_COMMON_STOP_BIT = 10;
  localparam int unsigned CFG_OVERRANGE_BIT = 3;
  localparam int unsigned CFG_VALID_CTRL_BIT = 5;
  localparam int unsigned CFG_SLIDE_EN_BIT = 7;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Data word flag positions
  localparam int unsigned DW_OVERFLOW_BIT = 12;
  localparam int unsigned DW_BELOW_BIT = 13;
  localparam int unsigned DW_NOT_VALID_BIT = 14;
  // Sliding scale bounds
  localparam logic [11:0] SLIDE_MAX_VALID = 12'hf00;
  // Output buffer
  localparam int unsigned FIFO_W = 21;
  localparam int unsigned FIFO_D = 8;
endpackage

// *** design/tdc_qual_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
module tdc_qual_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Reader takes word
  output logic [W-1:0] out_data // Head word
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem_ff [D]; // Storage
  logic [AW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp; // Pointers
  logic [AW:0] cnt_ff, nxt_cnt; // Fill level
  logic do_wr, do_rd;
  // Handshake and pointer update
  always_comb begin
    in_ready = (cnt_ff != (AW+1)'(D));
    out_valid = (cnt_ff != '0);
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    nxt_wp = do_wr ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = do_rd ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    out_data = mem_ff[rp_ff];
  end
  // Pointer registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
  // Storage array, no reset
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** design/tdc_conversion_data_qualifier.sv ***
`timescale 1ns/1ns
`default_nettype none
module tdc_conversion_data_qualifier #(
  parameter bit SIXTEEN_CH = 1'b0 // Select 16-channel variant timing
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [15:0] config_bits, // Second bit-set configuration word
  input wire logic thr_wr, // Threshold memory write strobe
  input wire logic [15:0] thr_addr, // Threshold memory byte address
  input wire logic [15:0] thr_wdata, // Threshold write data
  output logic [15:0] thr_rdata, // Threshold read data
  input wire logic common_timing_input, // Common start/stop pin
  input wire logic [tdc_qual_pkg::NUM_CH-1:0] ch_stop, // Channel timing pins
  input wire logic [tdc_qual_pkg::NUM_CH-1:0] ramp_saturated, // Ramp saturation pins
  input wire logic [11:0] adc_a, // Converter A result
  input wire logic [11:0] adc_b, // Converter B result
  input wire logic adc_a_ovf, // Converter A overflow
  input wire logic adc_b_ovf, // Converter B overflow
  input wire logic [11:0] slide_offset, // Sliding-scale known offset
  output logic [3:0] mux_sel, // Channel within group of 4
  output logic [1:0] group_sel, // Group within a converter half
  output logic common_timing_out, // Common timing to sections
  output logic [tdc_qual_pkg::NUM_CH-1:0] integrator_charge_switch, // Ramp running
  output logic [tdc_qual_pkg::NUM_CH-1:0] integrator_discharge_switch, // Clear per channel
  output logic busy, // Conversion in progress
  output logic out_valid, // Accepted datum ready
  input wire logic out_ready, // Host side takes datum
  output logic [20:0] out_data // {channel[4:0], data word[15:0]}
);
  localparam int unsigned NCH = tdc_qual_pkg::NUM_CH;
  localparam int unsigned CONV_CYC = SIXTEEN_CH ? tdc_qual_pkg::CONV_16CH_CYC : tdc_qual_pkg::CONV_32CH_CYC;
  localparam int unsigned STEPS = tdc_qual_pkg::HALF_CH;
  localparam int unsigned STEP_CYC = CONV_CYC / STEPS;

  typedef enum logic [1:0] {IDLE, ARMED, CONVERT, CLEAR} seq_e;

  // Pin synchronisers
  logic com_s1_ff, com_s2_ff, com_s3_ff;
  logic [NCH-1:0] stop_s1_ff, stop_s2_ff, stop_s3_ff, sat_s1_ff, sat_s2_ff;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      com_s1_ff <= 1'b0;
      com_s2_ff <= 1'b0;
      com_s3_ff <= 1'b0;
      stop_s1_ff <= '0;
      stop_s2_ff <= '0;
      stop_s3_ff <= '0;
      sat_s1_ff <= '0;
      sat_s2_ff <= '0;
    end else begin
      com_s1_ff <= common_timing_input;
      com_s2_ff <= com_s1_ff;
      com_s3_ff <= com_s2_ff;
      stop_s1_ff <= ch_stop;
      stop_s2_ff <= stop_s1_ff;
      stop_s3_ff <= stop_s2_ff;
      sat_s1_ff <= ramp_saturated;
      sat_s2_ff <= sat_s1_ff;
    end
  end
  logic com_rise;
  logic [NCH-1:0] stop_rise;
  assign com_rise = com_s2_ff && !com_s3_ff;
  assign stop_rise = stop_s2_ff & ~stop_s3_ff;

  // Config fields
  logic common_stop, step_fine, keep_below_limit_enable, keep_overrange_enable, valid_ctrl, slide_en;
  assign common_stop = config_bits[tdc_qual_pkg::CFG_COMMON_STOP_BIT];
  assign step_fine = config_bits[tdc_qual_pkg::CFG_STEP_BIT];
  assign keep_below_limit_enable = config_bits[tdc_qual_pkg::CFG_KEEP_BELOW_BIT];
  assign keep_overrange_enable = config_bits[tdc_qual_pkg::CFG_OVERRANGE_BIT];
  assign valid_ctrl = config_bits[tdc_qual_pkg::CFG_VALID_CTRL_BIT];
  assign slide_en = config_bits[tdc_qual_pkg::CFG_SLIDE_EN_BIT];

  logic [8:0] thr_mem [NCH];
  logic thr_hit;
  logic [4:0] thr_idx;
  assign thr_hit = (thr_addr >= tdc_qual_pkg::THR_MEM_BASE) && (thr_addr <= tdc_qual_pkg::THR_MEM_LAST);
  assign thr_idx = thr_addr[5:1];
  // Threshold memory write, 16-bit entries on even addresses
  always_ff @(posedge clk_sys) begin
    if (thr_wr && thr_hit) begin
      thr_mem[thr_idx] <= thr_wdata[8:0];
    end
  end
  // Threshold read data, registered
  logic [15:0] thr_rdata_ff, nxt_thr_rdata;
  always_comb begin
    nxt_thr_rdata = thr_hit ? {7'h00, thr_mem[thr_idx]} : 16'h0000;
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      thr_rdata_ff <= 16'h0000;
    end else begin
      thr_rdata_ff <= nxt_thr_rdata;
    end
  end
  assign thr_rdata = thr_rdata_ff;

  // Per-channel self-reset and not-valid tracking
  logic [NCH-1:0] not_valid_ff, nxt_not_valid;
  logic [9:0] rst_cnt_ff [NCH];
  logic [9:0] nxt_rst_cnt [NCH];
  logic [NCH-1:0] ramp_ff, nxt_ramp;
  logic clr_all;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      always_comb begin
        nxt_rst_cnt[gi] = rst_cnt_ff[gi];
        nxt_not_valid[gi] = not_valid_ff[gi];
        nxt_ramp[gi] = ramp_ff[gi];
        if (rst_cnt_ff[gi] != 10'h000) begin
          nxt_rst_cnt[gi] = rst_cnt_ff[gi] - 10'h001;
        end
        if (common_stop && sat_s2_ff[gi] && rst_cnt_ff[gi] == 10'h000) begin
          nxt_rst_cnt[gi] = 10'(tdc_qual_pkg::SELF_RESET_CYC);
          nxt_ramp[gi] = 1'b0;
        end
        // Ramp start: channel in stop mode, common in start mode
        if (common_stop ? (stop_rise[gi] && rst_cnt_ff[gi] == 10'h000) : com_rise) begin
          nxt_ramp[gi] = 1'b1;
        end
        // Ramp stop: common in stop mode, channel in start mode
        if (common_stop ? com_rise : stop_rise[gi]) begin
          nxt_ramp[gi] = 1'b0;
        end
        // stop during self-reset is not valid
        if (common_stop && com_rise && rst_cnt_ff[gi] != 10'h000) begin
          nxt_not_valid[gi] = 1'b1;
        end
        if (clr_all) begin
          nxt_not_valid[gi] = 1'b0;
          nxt_ramp[gi] = 1'b0;
        end
      end
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          rst_cnt_ff[gi] <= 10'h000;
          not_valid_ff[gi] <= 1'b0;
          ramp_ff[gi] <= 1'b0;
        end else begin
          rst_cnt_ff[gi] <= nxt_rst_cnt[gi];
          not_valid_ff[gi] <= nxt_not_valid[gi];
          ramp_ff[gi] <= nxt_ramp[gi];
        end
      end
    end
  endgenerate
  assign integrator_charge_switch = ramp_ff;

  // Threshold comparison; true means below limit
  function automatic logic below_limit(input logic [11:0] v, input logic [7:0] thr, input logic fine);
    if (fine) begin
      below_limit = (v[11:9] == 3'b000) && (v[8:1] < thr);
    end else begin
      // coarse step compares top 8 bits
      below_limit = v[11:4] < thr;
    end
  endfunction

  // Conversion sequencer
  seq_e st_ff, nxt_st;
  logic [9:0] cyc_ff, nxt_cyc;
  logic [3:0] step_ff, nxt_step;
  logic half_ff, nxt_half;
  logic wr_pend_ff, nxt_wr_pend;
  logic [20:0] wr_data_ff, nxt_wr_data;
  logic fifo_ready;
  logic [4:0] cur_ch;
  logic [11:0] raw, corr;
  logic ovf, bad_slide, below, killed, keep;
  logic [15:0] word;
  assign cur_ch = {half_ff, step_ff};
  // two converters, each on its own half
  assign raw = half_ff ? adc_b : adc_a;
  assign corr = slide_en ? raw - slide_offset : raw;
  // slide results above limit are incorrect
  assign bad_slide = slide_en && (corr > tdc_qual_pkg::SLIDE_MAX_VALID);
  assign ovf = (half_ff ? adc_b_ovf : adc_a_ovf) || bad_slide;
  assign below = below_limit(corr, thr_mem[cur_ch][7:0], step_fine);
  assign killed = thr_mem[cur_ch][tdc_qual_pkg::THR_KILL_BIT];
  assign keep = !killed && (!below || keep_below_limit_enable) && (!ovf || keep_overrange_enable)
                && (!not_valid_ff[cur_ch] || valid_ctrl);
  always_comb begin
    word = {4'h0, corr};
    word[tdc_qual_pkg::DW_OVERFLOW_BIT] = ovf;
    word[tdc_qual_pkg::DW_BELOW_BIT] = below;
    word[tdc_qual_pkg::DW_NOT_VALID_BIT] = not_valid_ff[cur_ch];
  end

  // sequence length set by the channel count regardless of active channels; a full buffer stretches it
  always_comb begin
    nxt_st = st_ff;
    nxt_cyc = cyc_ff;
    nxt_step = step_ff;
    nxt_half = half_ff;
    nxt_wr_pend = wr_pend_ff && !fifo_ready;
    nxt_wr_data = wr_data_ff;
    clr_all = 1'b0;
    unique case (st_ff)
      IDLE: begin
        // Wait for common edge
        if (com_rise) begin
          nxt_st = ARMED;
          nxt_cyc = 10'h000;
        end
      end
      ARMED: begin
        // Let stops settle half a step before sampling
        nxt_cyc = cyc_ff + 10'h001;
        if (cyc_ff == 10'(STEP_CYC / 2 - 1)) begin
          nxt_st = CONVERT;
          nxt_cyc = 10'h000;
          nxt_step = 4'h0;
          nxt_half = 1'b0;
        end
      end
      CONVERT: begin
        nxt_cyc = cyc_ff + 10'h001;
        // Half A mid-slot, half B next cycle; a full buffer stretches the slot
        if (cyc_ff == 10'(STEP_CYC / 2) || cyc_ff == 10'(STEP_CYC / 2 + 1)) begin
          if (wr_pend_ff && !fifo_ready) begin
            // Buffer full: hold the slot until the pending word leaves
            nxt_cyc = cyc_ff;
          end else begin
            if (keep) begin
              nxt_wr_pend = 1'b1;
              nxt_wr_data = {cur_ch, word};
            end
            nxt_half = !half_ff;
          end
        end
        // Slot end moves on to the next pair of channels
        if (cyc_ff == 10'(STEP_CYC - 1)) begin
          nxt_cyc = 10'h000;
          nxt_step = step_ff + 4'h1;
          if (step_ff == 4'(STEPS - 1)) begin
            nxt_st = CLEAR;
          end
        end
      end
      CLEAR: begin
        clr_all = 1'b1;
        nxt_cyc = cyc_ff + 10'h001;
        if (cyc_ff == 10'(tdc_qual_pkg::CLEAR_CYC - 1)) begin
          nxt_st = IDLE;
          nxt_cyc = 10'h000;
        end
      end
    endcase
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= IDLE;
      cyc_ff <= 10'h000;
      step_ff <= 4'h0;
      half_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_data_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      step_ff <= nxt_step;
      half_ff <= nxt_half;
      wr_pend_ff <= nxt_wr_pend;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // channel within group of 4 and group number
  assign mux_sel = 4'h1 << step_ff[1:0];
  assign group_sel = step_ff[3:2];
  // common timing and clears from control logic
  assign common_timing_out = com_s2_ff;
  assign integrator_discharge_switch = clr_all ? {NCH{1'b1}} : '0;
  assign busy = (st_ff != IDLE);

  // Accepted data buffer towards host memory
  tdc_qual_fifo #(.W(tdc_qual_pkg::FIFO_W), .D(tdc_qual_pkg::FIFO_D)) u_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(wr_pend_ff),
    .in_ready(fifo_ready),
    .in_data(wr_data_ff),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );
endmodule
`default_nettype wire

// *** test/host_reader.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host side reader of accepted data, able to stall
module host_reader (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic stall, // Hold off reading
  input wire logic out_valid, // Datum offered
  output logic out_ready, // Reader takes datum
  output logic take // Datum taken at this edge
);
  // host reads data
  // Ready only changes just after an edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= !stall;
    end
  end
  assign take = out_valid && out_ready;
endmodule
`default_nettype wire

// *** test/tdc_qual_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
// Port level checker for the qualifier
module tdc_qual_chk (
  input wire logic clk_sys, // System clock
  input wire logic rst_b, // Reset, active low
  input wire logic [15:0] config_bits, // Configuration word
  input wire logic thr_wr, // Threshold write
  input wire logic [15:0] thr_addr, // Threshold address
  input wire logic [15:0] thr_wdata, // Threshold data in
  input wire logic [15:0] thr_rdata, // Threshold data out
  input wire logic common_timing_input, // Common pin
  input wire logic busy, // Conversion busy
  input wire logic common_timing_out, // Synchronised common level
  input wire logic [tdc_qual_pkg::NUM_CH-1:0] integrator_charge_switch, // Ramps running
  input wire logic [3:0] mux_sel, // Channel in group
  input wire logic [tdc_qual_pkg::NUM_CH-1:0] integrator_discharge_switch, // Clears
  input wire logic out_valid, // Datum ready
  input wire logic out_ready, // Host takes datum
  input wire logic [20:0] out_data // Datum
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic in_rng; // Address inside threshold window
  assign in_rng = thr_addr >= tdc_qual_pkg::THR_MEM_BASE && thr_addr <= tdc_qual_pkg::THR_MEM_LAST;
  AST_THR_OUTSIDE: assert property (!in_rng |=> thr_rdata == 16'h0000)
    else $error("threshold read outside window not zero");
  AST_THR_BACK: assert property (thr_wr && in_rng ##1 !thr_wr && $stable(thr_addr)
    |=> thr_rdata[8:0] == $past(thr_wdata[8:0], 2)) else $error("threshold entry not read back");
  AST_BUSY_START: assert property (!busy && $rose(common_timing_input) |-> ##[1:4] busy)
    else $error("common edge did not start conversion");
  AST_CLEAR_END: assert property ($fell(busy) |-> $past(&integrator_discharge_switch))
    else $error("conversion ended without clear");
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("offered datum changed before taken");
  AST_NO_BELOW: assert property (out_valid |-> config_bits[4] || !out_data[13])
    else $error("below limit datum stored while discarding");
  AST_NO_OVF: assert property (out_valid |-> config_bits[3] || !out_data[12])
    else $error("overflow datum stored under suppression");
  AST_NO_NV: assert property (out_valid |-> config_bits[5] || !out_data[14])
    else $error("not valid datum stored under suppression");
  AST_SLIDE: assert property (out_valid && config_bits[7] |-> out_data[11:0] <= 12'hf00 || out_data[12])
    else $error("slide result above limit not flagged");
  AST_MUX: assert property ($onehot(mux_sel))
    else $error("channel select not one hot");
  AST_RAMP_CLEAR: assert property (&integrator_discharge_switch |=> !(|integrator_charge_switch))
    else $error("ramp still running after clear");
  AST_RAMP_START: assert property (!config_bits[10] && $rose(busy) |-> &integrator_charge_switch)
    else $error("common start did not start every ramp");
  AST_COMMON_OUT: assert property ($past(rst_b) && $past(rst_b, 2) |->
    common_timing_out == $past(common_timing_input, 2)) else $error("common timing out does not follow pin");
endmodule
bind tdc_conversion_data_qualifier tdc_qual_chk tdc_qual_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .config_bits(config_bits), .thr_wr(thr_wr), .thr_addr(thr_addr), .thr_wdata(thr_wdata),
  .thr_rdata(thr_rdata), .common_timing_input(common_timing_input), .busy(busy), .mux_sel(mux_sel),
  .common_timing_out(common_timing_out), .integrator_charge_switch(integrator_charge_switch),
  .integrator_discharge_switch(integrator_discharge_switch), .out_valid(out_valid),
  .out_ready(out_ready), .out_data(out_data));
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys = 1'b0; // System clock
  logic rst_b = 1'b0; // Reset, active low
  logic [15:0] config_bits = 16'h0000; // Configuration
  logic thr_wr = 1'b0; // Threshold write
  logic [15:0] thr_addr = 16'h0000; // Threshold address
  logic [15:0] thr_wdata = 16'h0000; // Threshold data
  logic [15:0] thr_rdata; // Threshold read back
  logic common_timing_input = 1'b0; // Common pin
  logic [31:0] ramp_saturated = 32'h0; // Saturation pins
  logic [11:0] adc_a = 12'h000, adc_b = 12'h000, slide_offset = 12'h000; // Converter values
  logic adc_b_ovf = 1'b0, stall = 1'b0; // Overflow, reader hold
  logic busy, out_valid, out_ready, take; // Status and handshake
  logic [20:0] out_data; // Accepted datum
  int bad_count = 0, checked = 0, blen = 0, base_len = 0; // Counters
  logic [15:0] thr [32]; // Threshold shadow
  logic hit [32]; // Channel seen
  logic [15:0] got [32]; // Word seen
  always #4 clk_sys = ~clk_sys;
  tdc_conversion_data_qualifier tdc_conversion_data_qualifier_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .config_bits(config_bits), .thr_wr(thr_wr), .thr_addr(thr_addr), .thr_wdata(thr_wdata),
    .thr_rdata(thr_rdata), .common_timing_input(common_timing_input), .ch_stop(32'h0),
    .ramp_saturated(ramp_saturated), .adc_a(adc_a), .adc_b(adc_b), .adc_a_ovf(1'b0),
    .adc_b_ovf(adc_b_ovf), .slide_offset(slide_offset), .mux_sel(), .group_sel(),
    .common_timing_out(), .integrator_charge_switch(), .integrator_discharge_switch(), .busy(busy),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));
  host_reader host_reader_i (.clk_sys(clk_sys), .rst_b(rst_b), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .take(take));
  // Capture each datum the reader takes
  always @(posedge clk_sys) begin
    if (take) begin
      hit[out_data[20:16]] <= 1'b1;
      got[out_data[20:16]] <= out_data[15:0];
    end
  end
  // Compare and count
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] seen);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Final report and verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Threshold entry write
  task automatic thr_set(input int ch, input logic [15:0] v);
    @(posedge clk_sys);
    thr_wr <= 1'b1;
    thr_addr <= 16'h1080 + 16'(2 * ch);
    thr_wdata <= v;
    @(posedge clk_sys);
    thr_wr <= 1'b0;
    thr[ch] = v;
  endtask
  // Threshold read, one cycle latency
  task automatic thr_get(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    thr_addr <= a;
    @(posedge clk_sys);
    @(posedge clk_sys);
    #1 v = thr_rdata;
  endtask
  // Expected {kept, word} of a channel
  function automatic logic [16:0] expect_w(int ch, logic [11:0] raw, logic ovf, int sat);
    logic [11:0] v;
    logic ov, below, nv;
    v = config_bits[7] ? raw - slide_offset : raw;
    ov = ovf || (config_bits[7] && v > 12'hf00);
    below = config_bits[8] ? (v[11:9] == 3'h0 && v[8:1] < thr[ch][7:0]) : (v[11:4] < thr[ch][7:0]);
    nv = config_bits[10] && ch == sat;
    if (thr[ch][8] || (below && !config_bits[4]) || (ov && !config_bits[3]) || (nv && !config_bits[5]))
      return 17'h00000;
    return {2'b10, nv, below, ov, v};
  endfunction
  // One conversion, then judge every channel
  task automatic convert(input logic [15:0] cfg, input logic [11:0] a, b, input logic ob, input int sat);
    int n;
    logic [16:0] exp_w; // Expected word of a channel
    @(posedge clk_sys);
    config_bits <= cfg;
    adc_a <= a;
    adc_b <= b;
    adc_b_ovf <= ob;
    for (int i = 0; i < 32; i++) hit[i] = 1'b0;
    if (sat >= 0) ramp_saturated[sat] <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ramp_saturated <= 32'h0;
    common_timing_input <= 1'b1;
    repeat (4) @(posedge clk_sys);
    common_timing_input <= 1'b0;
    blen = 0;
    while (busy === 1'b1 && blen < 20000) begin
      @(posedge clk_sys);
      blen++;
    end
    n = 0;
    while (out_valid !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      n++;
    end
    if (blen >= 20000 || n >= 2000) begin
      $display("wrong value wait expected done seen hung");
      bad_count++;
      test_done();
    end
    @(posedge clk_sys);
    for (int c = 0; c < 32; c++) begin
      exp_w = expect_w(c, c < 16 ? a : b, c < 16 ? 1'b0 : ob, sat);
      chk($sformatf("channel %0d", c), exp_w, {hit[c], hit[c] ? got[c] : 16'h0});
    end
  endtask
  // Threshold memory access
  task automatic t_regs;
    logic [15:0] v;
    for (int c = 0; c < 32; c++) thr_set(c, 16'h0000);
    thr_set(1, 16'h0100);
    thr_set(31, 16'h00a5);
    thr_get(16'h1082, v);
    chk("kill entry", 17'h00100, {8'h0, v[8:0]});
    thr_get(16'h10be, v);
    chk("last entry", 17'h000a5, {8'h0, v[8:0]});
    thr_get(16'h10c0, v);
    chk("outside entry", 17'h0, {1'b0, v});
    $display("test regs done");
  endtask
  // Qualification modes
  task automatic t_modes;
    thr_set(0, 16'h0011);
    thr_set(2, 16'h0010);
    convert(16'h0000, 12'h105, 12'h230, 1'b1, -1);
    base_len = blen;
    chk("conversion time", 17'h1, 17'(blen > 672 && blen < 752));
    convert(16'h0018, 12'h105, 12'h230, 1'b1, -1);
    chk("fixed busy length", 17'(base_len), 17'(blen));
    convert(16'h0110, 12'h020, 12'h200, 1'b0, -1);
    @(posedge clk_sys);
    slide_offset <= 12'h010;
    convert(16'h0088, 12'hf10, 12'hf11, 1'b0, -1);
    convert(16'h0400, 12'h300, 12'h300, 1'b0, 3);
    convert(16'h0420, 12'h300, 12'h300, 1'b0, 3);
    $display("test modes done");
  endtask
  // Reader stalls, buffer fills, then drains
  task automatic t_stall;
    stall <= 1'b1;
    fork
      convert(16'h0010, 12'h300, 12'h300, 1'b0, -1);
      begin
        repeat (500) @(posedge clk_sys);
        stall <= 1'b0;
      end
    join
    $display("test stall done");
  endtask
  // Reset in mid conversion keeps thresholds
  task automatic t_reset;
    logic [15:0] v;
    @(posedge clk_sys);
    common_timing_input <= 1'b1;
    repeat (50) @(posedge clk_sys);
    common_timing_input <= 1'b0;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    thr_get(16'h1080, v);
    chk("threshold after reset", 17'h00011, {8'h0, v[8:0]});
    $display("test reset done");
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs();
    t_modes();
    t_stall();
    t_reset();
    test_done();
  end
endmodule
`default_nettype wire
